// ===== shared/fsc_defines.vh
/*
 constants for the serial flash security-register read, two-frame reset and
 parameter-area read logic. assumes a 100 MHz core clock and a slower serial clock.
*/
// Contract
// - security read: opcode 48h, three address bytes, one dummy byte, sampled on rising sclk
// - after the dummy byte, data bits change on falling sclk edges
// - any start byte; the address advances by one after each output byte
// - low ten bits wrap 3ffh to 000h; output runs until chip select rises
// - bits 15:12 pick the register (000x, 0010, 0011); 23:16 and 11:10 zero
// - reset takes two frames: 66h, then 99h, chip select high after each
// - accepted reset aborts work and clears every volatile setting
// - after reset, commands are ignored about 30 us, or 12 ms after erase work
// - opcode 5ah reads the fixed parameter header area
// - signature 50444653h first, then revisions 00h/01h, count 01h, ffh fillers
// - first header: id 00h, revision 1.0, length 09h, pointer 000030h
// - second header: maker id, revision 1.0, length 03h, pointer 000060h, ffh
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_OP_SECREAD 8'h48
`define FSC_OP_RSTEN 8'h66
`define FSC_OP_RST 8'h99
`define FSC_OP_PARAM 8'h5A
`define FSC_CLK_MHZ 100
`define FSC_TRST_NS 30000
`define FSC_TRSTE_NS 12000000
`define FSC_TRST_CYC ((`FSC_TRST_NS * `FSC_CLK_MHZ) / 1000)
`define FSC_TRSTE_CYC ((`FSC_TRSTE_NS * `FSC_CLK_MHZ) / 1000)
`define FSC_WRAP_LAST 10'h3FF
`define FSC_HDR_LAST 8'h17
// arbitrary maker code, stands for no real vendor
`define FSC_MAKER_ID 8'h3C
`endif

// ===== core/fsc_param_rom.v
/*
 fixed parameter header area, byte addressed; bytes past the header read ffh.
 assumes a registered address from the command logic.
*/
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_param_rom (
   input wire [7:0] addr,
   output reg [7:0] data
);
   always @* begin
      case (addr)
         8'h00: data = 8'h53;
         8'h01: data = 8'h46;
         8'h02: data = 8'h44;
         8'h03: data = 8'h50;
         8'h04: data = 8'h00;
         8'h05: data = 8'h01;
         8'h06: data = 8'h01;
         8'h08: data = 8'h00;
         8'h09: data = 8'h00;
         8'h0A: data = 8'h01;
         8'h0B: data = 8'h09;
         8'h0C: data = 8'h30;
         8'h0D: data = 8'h00;
         8'h0E: data = 8'h00;
         8'h10: data = `FSC_MAKER_ID;
         8'h11: data = 8'h00;
         8'h12: data = 8'h01;
         8'h13: data = 8'h03;
         8'h14: data = 8'h60;
         8'h15: data = 8'h00;
         8'h16: data = 8'h00;
         default: data = 8'hFF;
      endcase
   end
endmodule

// ===== core/fsc_cmd.v
/*
 serial command logic: security register read, enable-reset/reset, parameter read.
 assumes cs_n, sclk and si come from pins and are oversampled by core_clk, which
 must run more than eight times the serial clock rate.
*/
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_cmd #(
   parameter [31:0] TRST_CYC = `FSC_TRST_CYC,
   parameter [31:0] TRSTE_CYC = `FSC_TRSTE_CYC
) (
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   input wire cs_n,
   input wire sclk,
   input wire si,
   input wire erase_active,
   input wire [7:0] sec_rd_data,
   output reg [11:0] sec_rd_addr,
   output reg [1:0] sec_rd_sel,
   output reg so,
   output reg so_oe_n,
   output reg reset_pulse,
   output reg reset_busy,
   output reg write_latch_flag,
   output reg suspend_flag,
   output reg [7:0] read_param_bits,
   output reg [7:0] continuous_read_bits,
   output reg [2:0] wrap_length_bits,
   input wire set_write_latch,
   input wire set_suspend,
   input wire [7:0] new_read_param,
   input wire [7:0] new_continuous_read,
   input wire [2:0] new_wrap_length,
   input wire load_settings
);
   localparam ST_CMD = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_DUMMY = 3'd2;
   localparam ST_OUT = 3'd3;
   localparam ST_SKIP = 3'd4;

   // three-stage pin synchronisers; stage 0 only feeds stage 1
   reg [2:0] cs_s, ck_s, si_s;
   reg cs_q, ck_q;
   reg [2:0] state;
   reg [7:0] shreg;
   reg [2:0] bitcnt;
   reg [1:0] bytecnt;
   reg [23:0] addr;
   reg is_param;
   reg armed;
   reg got_rst;
   reg [31:0] rst_cnt;
   reg [7:0] out_byte;
   wire [7:0] rom_data;
   wire [7:0] next_shreg;

   function addr_ok;
      input [23:0] a;
      begin
         addr_ok = (a[23:16] == 8'h00) && (a[11:10] == 2'b00) &&
            (a[15:13] == 3'b000 || a[15:12] == 4'b0010 || a[15:12] == 4'b0011);
      end
   endfunction

   function [1:0] reg_sel;
      input [23:0] a;
      begin
         reg_sel = (a[15:13] == 3'b000) ? 2'd0 : (a[12] ? 2'd2 : 2'd1);
      end
   endfunction

   fsc_param_rom u_rom (
      .addr(addr[7:0]),
      .data(rom_data)
   );

   wire cs_stable = (cs_s[1] == cs_s[2]);
   wire ck_stable = (ck_s[1] == ck_s[2]);
   wire cs_low = cs_stable ? ~cs_s[2] : ~cs_q;
   wire cs_rise = cs_stable && cs_s[2] && !cs_q;
   wire ck_level = ck_stable ? ck_s[2] : ck_q;
   wire ck_rise = ck_level && !ck_q && cs_low;
   wire ck_fall = !ck_level && ck_q && cs_low;
   assign next_shreg = {shreg[6:0], si_s[2]};

   always @(posedge core_clk) begin
      if (rst) begin
         cs_s <= 3'b111;
         ck_s <= 3'b000;
         si_s <= 3'b000;
         cs_q <= 1'b1;
         ck_q <= 1'b0;
      end else if (clk_en) begin
         cs_s <= {cs_s[1:0], cs_n};
         ck_s <= {ck_s[1:0], sclk};
         si_s <= {si_s[1:0], si};
         cs_q <= ~cs_low;
         ck_q <= ck_level;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         state <= ST_CMD;
         shreg <= 8'h00;
         bitcnt <= 3'd0;
         bytecnt <= 2'd0;
         addr <= 24'h00_0000;
         is_param <= 1'b0;
         armed <= 1'b0;
         got_rst <= 1'b0;
         so <= 1'b0;
         so_oe_n <= 1'b1;
         out_byte <= 8'h00;
         sec_rd_addr <= 12'h000;
         sec_rd_sel <= 2'd0;
      end else if (clk_en) begin
         got_rst <= 1'b0;
         if (cs_rise || !cs_low) begin
            // frame end: a lone 66h opcode arms, a lone 99h fires only right after a lone 66h frame
            if (cs_rise && state == ST_CMD && bitcnt == 3'd0 && !reset_busy) begin
               if (shreg == `FSC_OP_RSTEN) begin
                  armed <= 1'b1;
               end else begin
                  armed <= 1'b0;
                  got_rst <= armed && (shreg == `FSC_OP_RST);
               end
            end else if (cs_rise) begin
               armed <= 1'b0;
            end
            if (cs_rise) begin
               shreg <= 8'h00;
            end
            state <= ST_CMD;
            bitcnt <= 3'd0;
            bytecnt <= 2'd0;
            so_oe_n <= 1'b1;
         end else if (ck_rise) begin
            shreg <= next_shreg;
            bitcnt <= bitcnt + 3'd1;
            if (bitcnt == 3'd7) begin
               case (state)
                  ST_CMD: begin
                     bytecnt <= 2'd0;
                     if (reset_busy) begin
                        state <= ST_SKIP;
                     end else if (bytecnt != 2'd0) begin
                        // a reset opcode must be alone in its frame
                        state <= ST_SKIP;
                     end else if (next_shreg == `FSC_OP_SECREAD) begin
                        is_param <= 1'b0;
                        state <= ST_ADDR;
                     end else if (next_shreg == `FSC_OP_PARAM) begin
                        is_param <= 1'b1;
                        state <= ST_ADDR;
                     end else if (next_shreg != `FSC_OP_RSTEN && next_shreg != `FSC_OP_RST) begin
                        state <= ST_SKIP;
                     end else begin
                        bytecnt <= 2'd1;
                     end
                  end
                  ST_ADDR: begin
                     addr <= {addr[15:0], next_shreg};
                     bytecnt <= bytecnt + 2'd1;
                     if (bytecnt == 2'd2) begin
                        state <= ST_DUMMY;
                     end
                  end
                  ST_DUMMY: begin
                     // invalid security address: stay silent for the frame
                     if (!is_param && !addr_ok(addr)) begin
                        state <= ST_SKIP;
                     end else begin
                        state <= ST_OUT;
                     end
                     sec_rd_addr <= {2'b00, addr[9:0]};
                     sec_rd_sel <= reg_sel(addr);
                  end
                  default: state <= state;
               endcase
            end else if (state == ST_CMD && bitcnt == 3'd0) begin
               armed <= armed;
            end
         end else if (ck_fall && state == ST_OUT) begin
            so_oe_n <= 1'b0;
            if (bitcnt == 3'd0) begin
               // bytes 18h to ffh read ffh from the rom, which sees only addr[7:0]
               so <= is_param ? rom_data[7] : sec_rd_data[7];
               out_byte <= is_param ? rom_data : sec_rd_data;
            end else begin
               so <= out_byte[3'd7 - bitcnt];
               if (bitcnt == 3'd7) begin
                  addr[9:0] <= (addr[9:0] == `FSC_WRAP_LAST) ? 10'h000 : addr[9:0] + 10'h001;
                  sec_rd_addr[9:0] <= (addr[9:0] == `FSC_WRAP_LAST) ? 10'h000 : addr[9:0] + 10'h001;
                  if (is_param) begin
                     addr[23:10] <= addr[23:10];
                  end
               end
            end
         end
      end
   end

   // reset window: outputs ignored commands; long window when erase work was live
   always @(posedge core_clk) begin
      if (rst) begin
         rst_cnt <= 32'd0;
         reset_busy <= 1'b0;
         reset_pulse <= 1'b0;
      end else if (clk_en) begin
         reset_pulse <= got_rst;
         if (got_rst) begin
            rst_cnt <= erase_active ? TRSTE_CYC : TRST_CYC;
            reset_busy <= 1'b1;
         end else if (rst_cnt > 32'd1) begin
            rst_cnt <= rst_cnt - 32'd1;
         end else begin
            rst_cnt <= 32'd0;
            reset_busy <= 1'b0;
         end
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         write_latch_flag <= 1'b0;
         suspend_flag <= 1'b0;
         read_param_bits <= 8'h00;
         continuous_read_bits <= 8'h00;
         wrap_length_bits <= 3'b000;
      end else if (clk_en) begin
         if (got_rst) begin
            write_latch_flag <= 1'b0;
            suspend_flag <= 1'b0;
            read_param_bits <= 8'h00;
            continuous_read_bits <= 8'h00;
            wrap_length_bits <= 3'b000;
         end else begin
            if (set_write_latch) begin
               write_latch_flag <= 1'b1;
            end
            if (set_suspend) begin
               suspend_flag <= 1'b1;
            end
            if (load_settings) begin
               read_param_bits <= new_read_param;
               continuous_read_bits <= new_continuous_read;
               wrap_length_bits <= new_wrap_length;
            end
         end
      end
   end
endmodule

// ===== verification/fsc_cmd_chk.sv
/* port checker for fsc_cmd.
   assumes it is bound to every fsc_cmd instance and sees only its ports. */
`timescale 1ns/1ps
module fsc_cmd_chk (
   input wire core_clk,
   input wire rst,
   input wire cs_n,
   input wire so_oe_n,
   input wire reset_pulse,
   input wire reset_busy,
   input wire write_latch_flag,
   input wire suspend_flag,
   input wire [7:0] read_param_bits,
   input wire [7:0] continuous_read_bits,
   input wire [2:0] wrap_length_bits,
   input wire [11:0] sec_rd_addr,
   input wire [1:0] sec_rd_sel
);
   wire clr;
   assign clr = !write_latch_flag && !suspend_flag && read_param_bits == 8'h00 && continuous_read_bits == 8'h00
      && wrap_length_bits == 3'h0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // sync lag is 3 to 4 cycles, so 8 idle cycles must have released the line
   idle_release_a: assert property (cs_n [*8] |-> so_oe_n) else $error("output driven while deselected");
   pulse_busy_a: assert property (reset_pulse |=> reset_busy) else $error("no busy after reset");
   volatile_clear_a: assert property (reset_pulse |-> ##[0:1] clr) else $error("settings kept");
   busy_quiet_a: assert property (reset_busy |-> so_oe_n) else $error("output during reset window");
   addr_top_a: assert property (!so_oe_n |-> sec_rd_addr[11:10] == 2'b00) else $error("address top bits");
   sel_range_a: assert property (sec_rd_sel != 2'b11) else $error("bad register select");
   pulse_single_a: assert property (reset_pulse |=> !reset_pulse) else $error("reset pulse too long");
   addr_step_a: assert property (!so_oe_n && $past(so_oe_n) == 1'b0 && $changed(sec_rd_addr[9:0])
      |-> sec_rd_addr[9:0] == $past(sec_rd_addr[9:0]) + 10'd1) else $error("address step");
endmodule
bind fsc_cmd fsc_cmd_chk i_fsc_cmd_chk (.core_clk, .rst, .cs_n, .so_oe_n, .reset_pulse, .reset_busy,
   .write_latch_flag, .suspend_flag, .read_param_bits, .continuous_read_bits, .wrap_length_bits,
   .sec_rd_addr, .sec_rd_sel);

// ===== verification/fsc_host.sv
/* serial host controller model: chip select, mode 0 serial clock, data in/out.
   assumes the bench calls its tasks; pins move 1 ns after a falling core_clk, then every 62.5 ns. */
`timescale 1ns/1ps
module fsc_host (
   input wire core_clk,
   input wire so,
   output reg cs_n,
   output reg sclk,
   output reg si
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // half of the 125 ns link period; the 1 ns offset keeps pin moves off core edges
   task half;
      #62.5;
   endtask
   task open;
      begin
         @(negedge core_clk);
         #1;
         cs_n = 1'b0;
         half;
      end
   endtask
   task close;
      begin
         sclk = 1'b0;
         half;
         cs_n = 1'b1;
         si = ~si;
         half;
         half;
      end
   endtask
   // drive on the fall, take on the rise, msb first
   task xfer(input [7:0] tx, output [7:0] rx);
      integer n;
      for (n = 7; n >= 0; n = n - 1) begin
         sclk = 1'b0;
         si = tx[n];
         half;
         sclk = 1'b1;
         rx[n] = so;
         half;
      end
   endtask
endmodule

// ===== verification/fsc_cmd_tb.sv
/* self-checking bench for fsc_cmd.
   assumes fsc_host as far side and a combinational security memory model here. */
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_cmd_tb;
   localparam [31:0] TRST = 32'd400;
   localparam [31:0] TRSTE = 32'd600;
   reg core_clk, rst, clk_en, erase_active, set_write_latch, set_suspend, load_settings;
   reg [7:0] new_read_param, new_continuous_read;
   reg [2:0] new_wrap_length;
   wire cs_n, sclk, si, so, so_oe_n, reset_pulse, reset_busy, write_latch_flag, suspend_flag;
   wire [7:0] read_param_bits, continuous_read_bits, sec_rd_data;
   wire [2:0] wrap_length_bits;
   wire [11:0] sec_rd_addr;
   wire [1:0] sec_rd_sel;
   reg [31:0] seed = 32'h380c_4587;
   reg [191:0] tbl = {64'h5346_4450_0001_01ff, 64'h0000_0109_3000_00ff, `FSC_MAKER_ID, 56'h00_0103_6000_00ff};
   integer fails = 0, n_tests = 0, cyc = 0, pulses = 0, busy_len = 0, j, k, e, want;
   reg [7:0] b, st;
   reg [9:0] ad;
   reg oe_seen;
   fsc_cmd #(.TRST_CYC(TRST), .TRSTE_CYC(TRSTE)) i_fsc_cmd (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .cs_n(cs_n),
      .sclk(sclk),
      .si(si),
      .erase_active(erase_active),
      .sec_rd_data(sec_rd_data),
      .sec_rd_addr(sec_rd_addr),
      .sec_rd_sel(sec_rd_sel),
      .so(so),
      .so_oe_n(so_oe_n),
      .reset_pulse(reset_pulse),
      .reset_busy(reset_busy),
      .write_latch_flag(write_latch_flag),
      .suspend_flag(suspend_flag),
      .read_param_bits(read_param_bits),
      .continuous_read_bits(continuous_read_bits),
      .wrap_length_bits(wrap_length_bits),
      .set_write_latch(set_write_latch),
      .set_suspend(set_suspend),
      .new_read_param(new_read_param),
      .new_continuous_read(new_continuous_read),
      .new_wrap_length(new_wrap_length),
      .load_settings(load_settings)
   );
   // a released data line floats to its pull-up
   wire so_pin = so_oe_n ? 1'b1 : so;
   fsc_host i_fsc_host (.core_clk(core_clk), .so(so_pin), .cs_n(cs_n), .sclk(sclk), .si(si));
   function [7:0] mem(input [1:0] s, input [9:0] a);
      mem = a[7:0] ^ {a[9:8], s, 4'h5};
   endfunction
   assign sec_rd_data = mem(sec_rd_sel, sec_rd_addr[9:0]);
   function [7:0] hdr(input [7:0] a);
      hdr = (a < 8'h18) ? tbl[(23 - a) * 8 +: 8] : 8'hff;
   endfunction
   task rnd;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d fails %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task one(input [7:0] op);
      begin
         i_fsc_host.open;
         i_fsc_host.xfer(op, b);
         i_fsc_host.close;
      end
   endtask
   task lead(input [7:0] op, input [23:0] a);
      begin
         oe_seen = 1'b0;
         i_fsc_host.open;
         i_fsc_host.xfer(op, b);
         for (k = 2; k >= 0; k = k - 1) i_fsc_host.xfer(a[k * 8 +: 8], b);
         i_fsc_host.xfer(8'h00, b);
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (reset_pulse) pulses <= pulses + 1;
      if (reset_busy) busy_len <= busy_len + 1;
      if (!so_oe_n) oe_seen <= 1'b1;
      if (cyc == 60000) begin
         fails = fails + 1;
         results;
      end
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      {erase_active, set_write_latch, set_suspend, load_settings} = 4'h0;
      {new_read_param, new_continuous_read, new_wrap_length} = 19'h0;
      oe_seen = 1'b0;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      for (j = 0; j < 5; j = j + 1) begin
         rnd;
         ad = j[0] ? 10'h3fe : seed[9:0];
         lead(`FSC_OP_SECREAD, {(j == 4) ? 8'h01 : 8'h00, 2'b00, j[1:0], 2'b00, ad});
         for (k = 0; k < 4; k = k + 1) begin
            i_fsc_host.xfer(seed[7:0], b);
            chk(b, (j < 4) ? mem((j < 2) ? 2'd0 : j[1:0] - 2'd1, ad + k[9:0]) : 8'hff);
         end
         i_fsc_host.close;
         chk({7'h0, oe_seen}, (j < 4) ? 8'h01 : 8'h00);
      end
      $display("security read test done");
      for (j = 0; j < 2; j = j + 1) begin
         rnd;
         st = j ? {3'b000, seed[4:0]} % 8'h18 : 8'h00;
         lead(`FSC_OP_PARAM, {16'h0000, st});
         for (k = 0; k < (j ? 8 : 26); k = k + 1) begin
            i_fsc_host.xfer(seed[15:8], b);
            chk(b, hdr(st + k[7:0]));
         end
         i_fsc_host.close;
      end
      $display("parameter read test done");
      one(`FSC_OP_RSTEN);
      one(`FSC_OP_PARAM);
      one(`FSC_OP_RST);
      chk(pulses[7:0], 8'h00);
      for (e = 0; e < 2; e = e + 1) begin
         rnd;
         @(negedge core_clk);
         erase_active = e[0];
         {new_read_param, new_continuous_read, new_wrap_length} = seed[18:0] | 19'h1_2489;
         {load_settings, set_write_latch, set_suspend} = 3'b111;
         @(negedge core_clk);
         {load_settings, set_write_latch, set_suspend} = 3'b000;
         // status read before the reset, as a careful host does
         chk({write_latch_flag, suspend_flag, 3'b000, wrap_length_bits}, {5'b11000, new_wrap_length});
         chk(read_param_bits, new_read_param);
         chk(continuous_read_bits, new_continuous_read);
         busy_len = 0;
         one(`FSC_OP_RSTEN);
         one(`FSC_OP_RST);
         chk(pulses[7:0], e[7:0] + 8'h01);
         chk({1'b0, write_latch_flag, suspend_flag, wrap_length_bits, |read_param_bits, |continuous_read_bits}, 8'h00);
         // a frozen clock enable must stretch the reset window cycle for cycle
         if (!e[0]) begin
            @(negedge core_clk);
            clk_en = 1'b0;
            repeat (50) @(negedge core_clk);
            clk_en = 1'b1;
         end
         want = e[0] ? TRSTE : TRST + 50;
         lead(`FSC_OP_PARAM, 24'h00_0000);
         i_fsc_host.xfer(8'h00, b);
         i_fsc_host.close;
         chk({7'h0, oe_seen}, 8'h00);
         for (k = 0; k < 2000 && reset_busy; k = k + 1) @(negedge core_clk);
         chk({7'h0, busy_len >= want && busy_len <= want + 2}, 8'h01);
      end
      $display("reset test done");
      results;
   end
endmodule
